// >>> rtci_regs.vh
// Register map, field positions and reset values of the interval timer.
// Included by the prescaler, the timer top, the checker and the bench, not by the synchroniser; holds definitions only.
`ifndef RTCI_REGS_VH
`define RTCI_REGS_VH

// Byte offsets on the Avalon-MM slave, one 32-bit word each.
`define RTCI_OFS_CONTROL   5'h00
`define RTCI_OFS_COUNT     5'h04
`define RTCI_OFS_PERIOD    5'h08
`define RTCI_OFS_STATUS    5'h0C
`define RTCI_OFS_CLEAR     5'h10
`define RTCI_OFS_ENABLE    5'h14
`define RTCI_OFS_PRIORITY  5'h18

// Control register fields.
`define RTCI_BIT_RUN       15
`define RTCI_BIT_IDLE_HALT 13
`define RTCI_BIT_GATE      6
`define RTCI_BIT_PS_HI     5
`define RTCI_BIT_PS_LO     4
`define RTCI_BIT_SYNC      2
`define RTCI_BIT_SRC       1
`define RTCI_CONTROL_MASK  16'hA076

// Status, clear and enable share this layout.
`define RTCI_BIT_PERIOD_EV 0
`define RTCI_EV_WIDTH      1

// Reset values.
`define RTCI_RST_CONTROL   16'h0000
`define RTCI_RST_COUNT     16'h0000
`define RTCI_RST_PERIOD    16'hFFFF
`define RTCI_RST_PRIORITY  3'h0
`define RTCI_PRIO_WIDTH    3

// Prescale select codes and terminal counts (ratio minus one).
`define RTCI_PS_1          2'h0
`define RTCI_PS_8          2'h1
`define RTCI_PS_64         2'h2
`define RTCI_PS_256        2'h3
`define RTCI_PS_TC_1       8'h00
`define RTCI_PS_TC_8       8'h07
`define RTCI_PS_TC_64      8'h3F
`define RTCI_PS_TC_256     8'hFF

`endif

// >>> rtci_prescaler.v
// Prescaler that passes one of every 1, 8, 64 or 256 input pulses.
// Assumes single-cycle input pulses on ref_clk_i and a clock enable.
`timescale 1ns/100ps
`include "rtci_regs.vh"

module rtci_prescaler (
  // Clock and reset.
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // Control.
  input wire clear_i,
  input wire [1:0] prescale_select_i,
  // Pulses.
  input wire tick_i,
  output wire tick_o
);

  reg [7:0] div_ff;
  reg [7:0] terminal;

  always @* begin
    case (prescale_select_i)
      `RTCI_PS_1: terminal = `RTCI_PS_TC_1;
      `RTCI_PS_8: terminal = `RTCI_PS_TC_8;
      `RTCI_PS_64: terminal = `RTCI_PS_TC_64;
      `RTCI_PS_256: terminal = `RTCI_PS_TC_256;
      default: terminal = `RTCI_PS_TC_1;
    endcase
  end

  // A pulse leaves on the input pulse that meets the terminal count.
  assign tick_o = tick_i && (div_ff == terminal);

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_ff <= 8'h00;
    end else if (ce_i) begin
      if (clear_i || tick_o) begin
        div_ff <= 8'h00;
      end else if (tick_i) begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end

endmodule

// >>> rtci_sync.v
// Two-stage synchroniser with a pulse on either edge of the synchronised level.
// Assumes the input may change at any time relative to ref_clk_i.
`timescale 1ns/100ps

module rtci_sync (
  // Clock and reset.
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // Level in, edge out.
  input wire level_i,
  output wire edge_o
);

  reg meta_ff;
  reg stable_ff;
  reg last_ff;

  // Only the second stage reads the first, to keep metastability contained.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= 1'b0;
      stable_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (ce_i) begin
      meta_ff <= level_i;
      stable_ff <= meta_ff;
      last_ff <= stable_ff;
    end
  end

  assign edge_o = stable_ff ^ last_ff;

endmodule

// >>> rtci_timer.v
// Top of the 16-bit interval timer with its Avalon-MM register slave.
// Assumes one clock; the count input pin and gate are sampled on ref_clk_i.
//
// Summary of operation
// - 16-bit counter for time base or counting.
// - Can run from low-power crystal clock.
// - Asynchronous mode counts external input edges directly; the code finds the edges from samples of the pin taken on ref_clk_i.
// - Synchronised external input resynchronised after prescaler.
// - Timer modes internal clock; counter modes external.
// - Run bit 15 starts and stops counting.
// - Idle-halt bit 13 stops timer in idle.
// - Gate bit 6 gates internal clock only.
// - Prescale bits 5-4 divide 256/64/8/1.
// - Sync bit 2 used only with external clock.
// - Source bit 1 picks external or internal.
// - Unimplemented control bits read as zero.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`include "rtci_regs.vh"

module rtci_timer (
  // Clock, reset and clock enable.
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // Avalon-MM slave.
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Device and pin inputs.
  input wire external_count_input_i,
  input wire gate_i,
  input wire idle_i,
  // Interrupt.
  output wire irq_o,
  output wire [2:0] timer_irq_priority_o
);

  reg [15:0] timer1_control_ff;
  reg [15:0] count_ff;
  reg [15:0] period_value_ff;
  reg [`RTCI_EV_WIDTH-1:0] status_ff;
  reg [`RTCI_EV_WIDTH-1:0] timer_irq_enable_ff;
  reg [`RTCI_PRIO_WIDTH-1:0] prio_ff;
  reg ack_ff;
  reg [31:0] rdata_ff;
  reg ext_last_ff;
  reg sync_toggle_ff;

  reg [15:0] nxt_count;
  reg [31:0] rd_value;

  wire count_run;
  wire idle_halt;
  wire gated_accumulate;
  wire [1:0] prescale_select;
  wire ext_clock_sync_select;
  wire clock_source_select;
  wire active;
  wire ext_rise;
  wire raw_tick;
  wire ps_tick;
  wire synced_tick;
  wire count_tick;
  wire wrap;
  wire bus_req;
  wire wr_take;
  wire [15:0] wr_lo;

  // Merge byte lanes 0 and 1 of a write over an existing 16-bit value.
  function [15:0] lane_merge;
    input [15:0] old_value;
    input [31:0] wdata;
    input [3:0] be;
    begin
      lane_merge[7:0] = be[0] ? wdata[7:0] : old_value[7:0];
      lane_merge[15:8] = be[1] ? wdata[15:8] : old_value[15:8];
    end
  endfunction

  function hit;
    input [4:0] addr;
    input [4:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  assign count_run = timer1_control_ff[`RTCI_BIT_RUN];
  assign idle_halt = timer1_control_ff[`RTCI_BIT_IDLE_HALT];
  assign gated_accumulate = timer1_control_ff[`RTCI_BIT_GATE];
  assign prescale_select =
    timer1_control_ff[`RTCI_BIT_PS_HI:`RTCI_BIT_PS_LO];
  assign ext_clock_sync_select = timer1_control_ff[`RTCI_BIT_SYNC];
  assign clock_source_select = timer1_control_ff[`RTCI_BIT_SRC];

  // Counting needs the run bit and, when idle-halt is set, no idle.
  assign active = count_run && !(idle_halt && idle_i);

  // The pin may carry the 32 kHz crystal clock; its rising edges count.
  assign ext_rise = external_count_input_i && !ext_last_ff;

  // Internal source ticks every enabled cycle; gate applies to it only.
  assign raw_tick = clock_source_select ? ext_rise :
    (!gated_accumulate || gate_i);

  rtci_prescaler u_prescaler (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .clear_i(!active),
    .prescale_select_i(prescale_select),
    .tick_i(raw_tick && active),
    .tick_o(ps_tick)
  );

  // The prescaled external pulse crosses as a toggle into the counter.
  rtci_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .level_i(sync_toggle_ff),
    .edge_o(synced_tick)
  );

  // Synchronised counting adds three cycles of latency after the prescaler.
  assign count_tick = (clock_source_select && ext_clock_sync_select) ?
    (synced_tick && active) : ps_tick;

  assign wrap = count_tick && (count_ff == period_value_ff);

  always @* begin
    if (wrap) begin
      nxt_count = `RTCI_RST_COUNT;
    end else if (count_tick) begin
      nxt_count = count_ff + 16'h0001;
    end else begin
      nxt_count = count_ff;
    end
  end

  // Bus answers one cycle after the request appears.
  assign bus_req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req && !ack_ff;
  assign wr_take = avs_write_i && ack_ff;
  assign avs_readdata_o = rdata_ff;
  assign wr_lo = avs_writedata_i[15:0];

  always @* begin
    rd_value = 32'h00000000;
    case (avs_address_i)
      `RTCI_OFS_CONTROL: rd_value[15:0] =
        timer1_control_ff & `RTCI_CONTROL_MASK;
      `RTCI_OFS_COUNT: rd_value[15:0] = count_ff;
      `RTCI_OFS_PERIOD: rd_value[15:0] = period_value_ff;
      `RTCI_OFS_STATUS: rd_value[`RTCI_EV_WIDTH-1:0] = status_ff;
      `RTCI_OFS_ENABLE: rd_value[`RTCI_EV_WIDTH-1:0] = timer_irq_enable_ff;
      `RTCI_OFS_PRIORITY: rd_value[`RTCI_PRIO_WIDTH-1:0] = prio_ff;
      default: rd_value = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else if (ce_i) begin
      ack_ff <= bus_req && !ack_ff;
      if (avs_read_i && !ack_ff) begin
        rdata_ff <= rd_value;
      end
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer1_control_ff <= `RTCI_RST_CONTROL;
      period_value_ff <= `RTCI_RST_PERIOD;
      timer_irq_enable_ff <= {`RTCI_EV_WIDTH{1'b0}};
      prio_ff <= `RTCI_RST_PRIORITY;
    end else if (ce_i && wr_take) begin
      if (hit(avs_address_i, `RTCI_OFS_CONTROL)) begin
        timer1_control_ff <= lane_merge(timer1_control_ff,
          avs_writedata_i, avs_byteenable_i) & `RTCI_CONTROL_MASK;
      end
      if (hit(avs_address_i, `RTCI_OFS_PERIOD)) begin
        period_value_ff <= lane_merge(period_value_ff,
          avs_writedata_i, avs_byteenable_i);
      end
      if (hit(avs_address_i, `RTCI_OFS_ENABLE) && avs_byteenable_i[0]) begin
        timer_irq_enable_ff <= wr_lo[`RTCI_EV_WIDTH-1:0];
      end
      if (hit(avs_address_i, `RTCI_OFS_PRIORITY) && avs_byteenable_i[0])
      begin
        prio_ff <= wr_lo[`RTCI_PRIO_WIDTH-1:0];
      end
    end
  end

  // A software write to the count wins over a tick in the same cycle.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_ff <= `RTCI_RST_COUNT;
    end else if (ce_i) begin
      if (wr_take && hit(avs_address_i, `RTCI_OFS_COUNT)) begin
        count_ff <= lane_merge(count_ff, avs_writedata_i, avs_byteenable_i);
      end else begin
        count_ff <= nxt_count;
      end
    end
  end

  // A wrap in the clearing cycle keeps its flag: the set wins.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_ff <= {`RTCI_EV_WIDTH{1'b0}};
    end else if (ce_i) begin
      if (wr_take && hit(avs_address_i, `RTCI_OFS_CLEAR) &&
          avs_byteenable_i[0]) begin
        status_ff <= (status_ff & ~wr_lo[`RTCI_EV_WIDTH-1:0]) |
          {`RTCI_EV_WIDTH{wrap}};
      end else if (wrap) begin
        status_ff[`RTCI_BIT_PERIOD_EV] <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_last_ff <= 1'b0;
      sync_toggle_ff <= 1'b0;
    end else if (ce_i) begin
      ext_last_ff <= external_count_input_i;
      if (ps_tick && clock_source_select && ext_clock_sync_select) begin
        sync_toggle_ff <= !sync_toggle_ff;
      end
    end
  end

  assign irq_o = |(status_ff & timer_irq_enable_ff);
  assign timer_irq_priority_o = prio_ff;

endmodule

// >>> rtci_timer_sva.sv
// Concurrent checks on the interval timer's bus and interrupt ports.
// Bound to rtci_timer; sees only the top module's ports.
`timescale 1ns/100ps
`include "rtci_regs.vh"
module rtci_timer_chk (
  // Clock and reset.
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // Bus and outputs.
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire irq_o,
  input wire [2:0] timer_irq_priority_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire req = avs_read_i | avs_write_i;
  wire rd_done = avs_read_i & ~avs_waitrequest_o;
  AST_WAIT_RISE: assert property ($rose(avs_write_i) && ce_i |->
    avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("write unanswered");
  AST_IDLE_BUS: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  AST_WAIT_ONE: assert property (req && ce_i && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("more than one wait cycle");
  AST_CTRL_MASK: assert property (rd_done &&
    avs_address_i == `RTCI_OFS_CONTROL |->
    (avs_readdata_o & ~{16'h0000, `RTCI_CONTROL_MASK}) == 32'h0)
    else $error("unimplemented control bit reads one");
  AST_CLEAR_RD: assert property (rd_done &&
    avs_address_i == `RTCI_OFS_CLEAR |-> avs_readdata_o == 32'h0)
    else $error("clear register reads nonzero");
  AST_UNMAPPED: assert property (rd_done && avs_address_i > 5'h18
    |-> avs_readdata_o == 32'h0) else $error("unmapped read nonzero");
  AST_PRIO_SRC: assert property ($changed(timer_irq_priority_o) |->
    $past(avs_write_i && !avs_waitrequest_o &&
    avs_address_i == `RTCI_OFS_PRIORITY)) else $error("priority moved");
  AST_CE_HOLD: assert property (!ce_i |=> $stable(avs_readdata_o) &&
    $stable(timer_irq_priority_o)) else $error("state moved without ce");
  cover property ($rose(irq_o));
  cover property (rd_done && avs_address_i == `RTCI_OFS_COUNT);
  cover property ($changed(timer_irq_priority_o));
endmodule
bind rtci_timer rtci_timer_chk i_rtci_timer_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
  .timer_irq_priority_o(timer_irq_priority_o)
);

// >>> rtci_xtal.sv
// Behavioural low-power crystal feeding the external count pin.
// Free of ref_clk_i; the pin rests low while the oscillator is stopped.
`timescale 1ns/100ps
module rtci_xtal #(parameter real HALF = 170.1) (
  // Control and pin.
  input wire run_i,
  output reg clk_o
);
  initial clk_o = 1'b0;
  // Period is scaled down from 32 kHz to keep runs short.
  // The odd half period keeps pin edges off the sampling clock edges.
  always begin
    wait (run_i);
    #HALF clk_o = 1'b1;
    #HALF clk_o = 1'b0;
  end
endmodule

// >>> rtci_timer_tb_top.sv
// Self-checking bench for the interval timer over Avalon-MM.
// Assumes rtci_xtal drives the count pin and the checker is bound.
`timescale 1ns/100ps
`include "rtci_regs.vh"
module rtci_timer_tb_top;
  reg ref_clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg ce_i = 1'b1;
  reg [4:0] addr = 5'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg gate = 1'b0;
  reg idle = 1'b0;
  reg xt_run = 1'b0;
  wire pin;
  wire [31:0] rdata;
  wire waitreq;
  wire irq;
  wire [2:0] prio;
  integer fails = 0;
  integer samples_checked = 0;
  integer i;
  integer r;
  reg [31:0] q;
  always #20 ref_clk_i = ~ref_clk_i;
  rtci_xtal i_rtci_xtal (.run_i(xt_run), .clk_o(pin));
  rtci_timer i_rtci_timer (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .ce_i(ce_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .external_count_input_i(pin), .gate_i(gate), .idle_i(idle),
    .irq_o(irq), .timer_irq_priority_o(prio));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  // The request holds until the rising edge that sees waitrequest low; read
  // data is taken at that edge, and one idle edge follows the release.
  task bus(input w, input [4:0] a, input [15:0] d);
    integer n;
    begin
      addr <= a;
      wdata <= {16'h0000, d};
      wr <= w;
      rd <= ~w;
      n = 0;
      do begin
        @(posedge ref_clk_i);
        n = n + 1;
        if (n > 20) begin
          fails = fails + 1;
          tally_and_finish;
        end
      end while (waitreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge ref_clk_i);
    end
  endtask
  task run_chk(input [15:0] ctl, input integer w, lo, hi);
    begin
      bus(1, `RTCI_OFS_COUNT, 16'h0000);
      bus(1, `RTCI_OFS_CONTROL, ctl | 16'h8000);
      repeat (w) @(posedge ref_clk_i);
      bus(1, `RTCI_OFS_CONTROL, ctl);
      bus(0, `RTCI_OFS_COUNT, 16'h0000);
      chk({31'h0, q[15:0] >= lo && q[15:0] <= hi}, 32'h1);
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        bus(0, {i[2:0], 2'b00}, 16'h0000);
        chk(q, (i == 2) ? 32'hFFFF : 32'h0);
      end
      ce_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      ce_i <= 1'b1;
      bus(1, `RTCI_OFS_CONTROL, 16'hFFFF);
      bus(0, `RTCI_OFS_CONTROL, 16'h0000);
      chk(q, 32'hA076);
      bus(1, `RTCI_OFS_CONTROL, 16'h0000);
      bus(1, 5'h1C, 16'hFFFF);
      bus(0, 5'h1C, 16'h0000);
      chk(q, 32'h0);
    end
  endtask
  task t_scale;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        r = (i == 3) ? 256 : (1 << (3 * i));
        run_chk({10'h0, i[1:0], 4'h0}, 4*r+r/2+8, (4*r+r/2+5)/r,
          (4*r+r/2+11)/r);
        chk(q, {16'h0, q[15:0]});
        r = q;
        bus(0, `RTCI_OFS_COUNT, 16'h0000);
        chk(q, r);
      end
    end
  endtask
  task t_modes;
    begin
      gate <= 1'b0;
      run_chk(16'h0040, 40, 0, 0);
      gate <= 1'b1;
      run_chk(16'h0040, 40, 37, 43);
      run_chk(16'h0002, 40, 0, 0);
      run_chk(16'h0004, 40, 37, 43);
      xt_run <= 1'b1;
      gate <= 1'b0;
      run_chk(16'h0042, 170, 18, 22);
      run_chk(16'h0006, 170, 18, 22);
      xt_run <= 1'b0;
      idle <= 1'b1;
      run_chk(16'h2000, 40, 0, 0);
      run_chk(16'h0000, 40, 37, 43);
      idle <= 1'b0;
    end
  endtask
  task t_irq;
    begin
      bus(1, `RTCI_OFS_PRIORITY, 16'h0005);
      chk({29'h0, prio}, 32'h5);
      bus(1, `RTCI_OFS_COUNT, 16'h0000);
      bus(1, `RTCI_OFS_PERIOD, 16'h0003);
      bus(1, `RTCI_OFS_ENABLE, 16'h0001);
      bus(1, `RTCI_OFS_CONTROL, 16'h8000);
      for (i = 0; i < 50 && irq !== 1'b1; i = i + 1)
        @(negedge ref_clk_i);
      chk({31'h0, irq}, 32'h1);
      @(posedge ref_clk_i);
      bus(0, `RTCI_OFS_COUNT, 16'h0000);
      chk({31'h0, q <= 32'h3}, 32'h1);
      bus(1, `RTCI_OFS_CONTROL, 16'h0000);
      bus(1, `RTCI_OFS_CLEAR, 16'h0001);
      chk({31'h0, irq}, 32'h0);
      bus(1, `RTCI_OFS_ENABLE, 16'h0000);
      run_chk(16'h0000, 20, 0, 3);
      bus(0, `RTCI_OFS_STATUS, 16'h0000);
      chk(q, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1, `RTCI_OFS_ENABLE, 16'h0001);
      chk({31'h0, irq}, 32'h1);
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_regs;
    t_scale;
    t_modes;
    t_irq;
    tally_and_finish;
  end
endmodule
